/* File: rtl/cps_hdlc_pkg.sv */
/*
  Shared types and constants for the CPS packet to HDLC disassembly
  block: register offsets, descriptor word layouts, header codes and
  the framing constants. Assumes a single clock domain.
*/
package cps_hdlc_pkg;
  localparam logic [4:0] ADR_W0 = 5'h00;
  localparam logic [4:0] ADR_W2 = 5'h02;
  localparam logic [4:0] ADR_W4 = 5'h04;
  localparam logic [4:0] ADR_W6 = 5'h06;
  localparam logic [4:0] ADR_W8 = 5'h08;
  localparam logic [4:0] ADR_W10 = 5'h10;
  localparam logic [4:0] ADR_STAT = 5'h12;
  localparam logic [4:0] ADR_MASK = 5'h14;
  localparam logic [4:0] ADR_CFG = 5'h16;

  localparam logic [2:0] HDR_NONE = 3'h0;
  localparam logic [2:0] HDR_A1 = 3'h1;
  localparam logic [2:0] HDR_A2 = 3'h2;
  localparam logic [2:0] HDR_A1C = 3'h3;
  localparam logic [2:0] HDR_A2C = 3'h4;

  localparam logic [7:0] FLAG_BYTE = 8'h7E;
  localparam logic [7:0] ESC_BYTE = 8'h7D;
  localparam logic [7:0] ESC_XOR = 8'h20;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [2:0] ONES_MAX = 3'h5;
  localparam logic [3:0] BITS_BYTE = 4'h8;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_HDR = 5'h02,
    S_DATA = 5'h04,
    S_CRC = 5'h08,
    S_FLAG = 5'h10
  } fsm_t;

  // descriptor word at 0x00
  typedef struct packed {
    logic rsv;
    logic [2:0] hdr_type;
    logic crc_en;
    logic loss_report_en;
    logic init;
    logic [8:0] wp;
  } w0_t;

  // descriptor word at 0x08
  typedef struct packed {
    logic [1:0] rsv;
    logic ref_a_en;
    logic ref_b_en;
    logic [2:0] rsv2;
    logic uui_in_control_en;
    logic [7:0] ctl;
  } w8_t;

  // descriptor word at 0x10
  typedef struct packed {
    logic [1:0] rsv;
    logic [5:0] exp_li;
    logic length_error_report_en;
    logic uui_error_report_en;
    logic rsv2;
    logic [4:0] seq_bits_match_sel;
  } w10_t;

  // global configuration word
  typedef struct packed {
    logic [7:0] rsv;
    logic [3:0] exp_uui;
    logic [2:0] rsv2;
    logic bitwise;
  } cfg_t;

  typedef struct packed {
    logic loss;
    logic uui;
    logic len;
  } evt_t;

  typedef struct packed {
    logic [5:0] li;
    logic [4:0] uui;
    logic timing;
  } pkt_t;

  typedef struct packed {
    logic we;
    logic [8:0] addr;
    logic [7:0] data;
  } wr_t;
endpackage

/* File: rtl/cps_hdlc_disasm.sv */
/*
  Receive disassembly of CPS packets into HDLC framed bytes for one
  channel, with its descriptor registers, error reporting and circular
  buffer pointers. Assumes the circular buffer memory sits outside and
  that all inputs are synchronous to CLK.
*/
// Summary of operation
// - length mismatch raises a report when length reporting is enabled
// - uui mismatch raises a report when uui reporting is enabled
// - lowest set bit of selector gives sequence bits and uui match mask
// - header type code picks none, one or two address bytes, control
// - crc enable appends a 16-bit trailing crc per packet
// - loss errors reported only while loss reporting is enabled
// - loss seen by buffer overflow, queue overrun or sequence error
// - software clears init bit, hardware sets it on first packet
// - 9-bit write pointer marks where the next byte is written
// - 9-bit read pointer marks next byte read toward the tdm side
// - 10-bit stream number routes the channel to a stream
// - 16-bit address field forms header address, unused for none
// - timing packet pulses recovery channel a and or b if enabled
// - send-uui puts uui in top five control bits for codes 011/100
// - control field forms the control byte only for codes 011/100
// - length compared to 6-bit expected value, packet still handled
// - bit-wise zero insertion or byte-wise escaping before buffer writes
`timescale 1ns/1ps
`default_nettype none
module cps_hdlc_disasm (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic PKT_VALID,
  input wire cps_hdlc_pkg::pkt_t PKT,
  output logic PKT_READY,
  input wire logic IN_VALID,
  input wire logic [7:0] IN_DATA,
  input wire logic IN_LAST,
  output logic IN_READY,
  input wire logic DESC_OVERRUN,
  output cps_hdlc_pkg::wr_t BUF_WR,
  input wire logic RD_REQ,
  output logic RD_VALID,
  output logic [8:0] RD_ADDR,
  output logic RD_EMPTY,
  output logic [9:0] STREAM_NUM,
  output logic REF_A,
  output logic REF_B,
  output cps_hdlc_pkg::evt_t REPORT,
  output logic IRQ
);
  typedef struct packed {
    cps_hdlc_pkg::fsm_t fsm;
    cps_hdlc_pkg::w0_t w0;
    logic [8:0] rp;
    logic [9:0] stream;
    logic [15:0] haddr;
    cps_hdlc_pkg::w8_t w8;
    cps_hdlc_pkg::w10_t w10;
    cps_hdlc_pkg::cfg_t cfg;
    cps_hdlc_pkg::evt_t status;
    cps_hdlc_pkg::evt_t mask;
    cps_hdlc_pkg::evt_t rep;
    logic [15:0] rdata;
    logic [4:0] uui;
    logic [3:0] last_seq;
    logic [1:0] hidx;
    logic cidx;
    logic [15:0] crc;
    logic st_v;
    logic st_raw;
    logic [7:0] sh;
    logic [3:0] n;
    logic [2:0] ones;
    logic [7:0] acc;
    logic [3:0] accn;
    logic ovf;
    cps_hdlc_pkg::wr_t bw;
    logic rd_valid;
    logic [8:0] rd_addr;
    logic ref_a;
    logic ref_b;
  } st_t;

  st_t q;
  st_t next_q;

  function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                          input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ cps_hdlc_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic [3:0] mmask;
  logic [3:0] smask;
  logic [1:0] hcnt;
  logic two_addr;
  logic [7:0] ctl_byte;
  logic [7:0] hbyte;
  logic full;
  logic bitv;
  logic do_wr;
  logic [7:0] wdat;
  cps_hdlc_pkg::evt_t ev;
  cps_hdlc_pkg::evt_t clr;

  // match mask on the upper uui bits, sequence bits below it
  always_comb begin
    priority casez (q.w10.seq_bits_match_sel)
      5'b????1: mmask = 4'hF;
      5'b???10: mmask = 4'hE;
      5'b??100: mmask = 4'hC;
      5'b?1000: mmask = 4'h8;
      default: mmask = 4'h0;
    endcase
    smask = (q.w10.seq_bits_match_sel == 5'h00) ? 4'h0 : ~mmask;
  end

  // header layout; reserved codes are framed as no header
  always_comb begin
    two_addr = (q.w0.hdr_type == cps_hdlc_pkg::HDR_A2) ||
               (q.w0.hdr_type == cps_hdlc_pkg::HDR_A2C);
    case (q.w0.hdr_type)
      cps_hdlc_pkg::HDR_A1: hcnt = 2'h0;
      cps_hdlc_pkg::HDR_A2: hcnt = 2'h1;
      cps_hdlc_pkg::HDR_A1C: hcnt = 2'h1;
      cps_hdlc_pkg::HDR_A2C: hcnt = 2'h2;
      default: hcnt = 2'h0;
    endcase
    ctl_byte = q.w8.uui_in_control_en ? {q.uui, q.w8.ctl[2:0]}
                                      : q.w8.ctl;
    if (two_addr && q.hidx == 2'h0) begin
      hbyte = q.haddr[15:8];
    end else if (q.hidx == (two_addr ? 2'h1 : 2'h0)) begin
      hbyte = q.haddr[7:0];
    end else begin
      hbyte = ctl_byte;
    end
  end

  assign full = (q.w0.wp + 9'h001) == q.rp;
  assign PKT_READY = (q.fsm == cps_hdlc_pkg::S_IDLE);
  assign IN_READY = (q.fsm == cps_hdlc_pkg::S_DATA) && !q.st_v;
  assign RD_EMPTY = (q.w0.wp == q.rp);
  assign IRQ = |(q.status & q.mask);

  always_comb begin
    next_q = q;
    ev = '0;
    clr = '0;
    bitv = 1'b0;
    do_wr = 1'b0;
    wdat = q.sh;
    next_q.bw.we = 1'b0;
    next_q.rd_valid = 1'b0;
    next_q.ref_a = 1'b0;
    next_q.ref_b = 1'b0;

    if (WR) begin
      case (ADDR)
        cps_hdlc_pkg::ADR_W0: next_q.w0 = WDATA;
        cps_hdlc_pkg::ADR_W2: next_q.rp = WDATA[8:0];
        cps_hdlc_pkg::ADR_W4: next_q.stream = WDATA[9:0];
        cps_hdlc_pkg::ADR_W6: next_q.haddr = WDATA;
        cps_hdlc_pkg::ADR_W8: next_q.w8 = WDATA;
        cps_hdlc_pkg::ADR_W10: next_q.w10 = WDATA;
        cps_hdlc_pkg::ADR_STAT: clr = WDATA[2:0];
        cps_hdlc_pkg::ADR_MASK: next_q.mask = WDATA[2:0];
        cps_hdlc_pkg::ADR_CFG: next_q.cfg = WDATA;
        default: ;
      endcase
    end
    next_q.rdata = 16'h0000;
    if (RD) begin
      case (ADDR)
        cps_hdlc_pkg::ADR_W0: next_q.rdata = q.w0;
        cps_hdlc_pkg::ADR_W2: next_q.rdata = {7'h00, q.rp};
        cps_hdlc_pkg::ADR_W4: next_q.rdata = {6'h00, q.stream};
        cps_hdlc_pkg::ADR_W6: next_q.rdata = q.haddr;
        cps_hdlc_pkg::ADR_W8: next_q.rdata = q.w8;
        cps_hdlc_pkg::ADR_W10: next_q.rdata = q.w10;
        cps_hdlc_pkg::ADR_STAT: next_q.rdata = {13'h0000, q.status};
        cps_hdlc_pkg::ADR_MASK: next_q.rdata = {13'h0000, q.mask};
        cps_hdlc_pkg::ADR_CFG: next_q.rdata = q.cfg;
        default: next_q.rdata = 16'h0000;
      endcase
    end

    // stuffing stage: one output bit or one output byte per cycle
    if (q.st_v) begin
      if (q.cfg.bitwise) begin
        if (q.ones == cps_hdlc_pkg::ONES_MAX) begin
          bitv = 1'b0;
          next_q.ones = 3'h0;
        end else begin
          bitv = q.sh[0];
          next_q.sh = q.sh >> 1;
          next_q.n = q.n - 4'h1;
          next_q.ones = (q.st_raw || !bitv) ? 3'h0 : q.ones + 3'h1;
          next_q.st_v = (q.n != 4'h1);
        end
        next_q.acc = {bitv, q.acc[7:1]};
        next_q.accn = q.accn + 4'h1;
        if (next_q.accn == cps_hdlc_pkg::BITS_BYTE) begin
          do_wr = 1'b1;
          wdat = next_q.acc;
          next_q.accn = 4'h0;
        end
      end else if (!q.st_raw && (q.sh == cps_hdlc_pkg::FLAG_BYTE ||
                                 q.sh == cps_hdlc_pkg::ESC_BYTE)) begin
        do_wr = 1'b1;
        wdat = cps_hdlc_pkg::ESC_BYTE;
        next_q.sh = q.sh ^ cps_hdlc_pkg::ESC_XOR;
        next_q.st_raw = 1'b1;
      end else begin
        do_wr = 1'b1;
        next_q.st_v = 1'b0;
      end
    end

    // a full buffer drops the byte rather than overwrite unread data
    if (do_wr) begin
      if (full) begin
        ev.loss = !q.ovf;
        next_q.ovf = 1'b1;
      end else begin
        next_q.bw.we = 1'b1;
        next_q.bw.addr = q.w0.wp;
        next_q.bw.data = wdat;
        next_q.w0.wp = q.w0.wp + 9'h001;
      end
    end

    if (RD_REQ && q.w0.wp != q.rp) begin
      next_q.rd_valid = 1'b1;
      next_q.rd_addr = q.rp;
      next_q.rp = q.rp + 9'h001;
    end

    case (q.fsm)
      cps_hdlc_pkg::S_IDLE: begin
        if (PKT_VALID) begin
          next_q.uui = PKT.uui;
          next_q.last_seq = PKT.uui[3:0];
          next_q.w0.init = 1'b1;
          next_q.ovf = 1'b0;
          next_q.hidx = 2'h0;
          next_q.crc = cps_hdlc_pkg::CRC_INIT;
          ev.len = q.w10.length_error_report_en &&
                   (PKT.li != q.w10.exp_li);
          ev.uui = q.w10.uui_error_report_en &&
                   ((PKT.uui[3:0] & mmask) !=
                    (q.cfg.exp_uui & mmask));
          ev.loss = q.w0.init && ((PKT.uui[3:0] & smask) !=
                    ((q.last_seq + 4'h1) & smask));
          next_q.ref_a = PKT.timing && q.w8.ref_a_en;
          next_q.ref_b = PKT.timing && q.w8.ref_b_en;
          if (q.w0.hdr_type == cps_hdlc_pkg::HDR_NONE ||
              q.w0.hdr_type > cps_hdlc_pkg::HDR_A2C) begin
            next_q.fsm = cps_hdlc_pkg::S_DATA;
          end else begin
            next_q.fsm = cps_hdlc_pkg::S_HDR;
          end
        end
      end
      cps_hdlc_pkg::S_HDR: begin
        if (!q.st_v) begin
          next_q.st_v = 1'b1;
          next_q.st_raw = 1'b0;
          next_q.sh = hbyte;
          next_q.n = cps_hdlc_pkg::BITS_BYTE;
          next_q.crc = crc_upd(q.crc, hbyte);
          next_q.hidx = q.hidx + 2'h1;
          if (q.hidx == hcnt) begin
            next_q.fsm = cps_hdlc_pkg::S_DATA;
          end
        end
      end
      cps_hdlc_pkg::S_DATA: begin
        if (!q.st_v && IN_VALID) begin
          next_q.st_v = 1'b1;
          next_q.st_raw = 1'b0;
          next_q.sh = IN_DATA;
          next_q.n = cps_hdlc_pkg::BITS_BYTE;
          next_q.crc = crc_upd(q.crc, IN_DATA);
          next_q.cidx = 1'b0;
          if (IN_LAST) begin
            next_q.fsm = q.w0.crc_en ? cps_hdlc_pkg::S_CRC
                                     : cps_hdlc_pkg::S_FLAG;
          end
        end
      end
      cps_hdlc_pkg::S_CRC: begin
        if (!q.st_v) begin
          next_q.st_v = 1'b1;
          next_q.st_raw = 1'b0;
          next_q.sh = q.cidx ? ~q.crc[15:8] : ~q.crc[7:0];
          next_q.n = cps_hdlc_pkg::BITS_BYTE;
          next_q.cidx = 1'b1;
          if (q.cidx) begin
            next_q.fsm = cps_hdlc_pkg::S_FLAG;
          end
        end
      end
      cps_hdlc_pkg::S_FLAG: begin
        if (!q.st_v) begin
          next_q.st_v = 1'b1;
          next_q.st_raw = 1'b1;
          next_q.sh = cps_hdlc_pkg::FLAG_BYTE;
          next_q.n = cps_hdlc_pkg::BITS_BYTE;
          next_q.fsm = cps_hdlc_pkg::S_IDLE;
        end
      end
      default: next_q.fsm = cps_hdlc_pkg::S_IDLE;
    endcase

    if (DESC_OVERRUN) begin
      ev.loss = 1'b1;
    end
    ev.loss = ev.loss && q.w0.loss_report_en;
    next_q.rep = ev;
    next_q.status = (q.status & ~clr) | ev;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
      q.fsm <= cps_hdlc_pkg::S_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign RDATA = q.rdata;
  assign BUF_WR = q.bw;
  assign RD_VALID = q.rd_valid;
  assign RD_ADDR = q.rd_addr;
  assign STREAM_NUM = q.stream;
  assign REF_A = q.ref_a;
  assign REF_B = q.ref_b;
  assign REPORT = q.rep;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_accept;
    PKT_VALID && q.fsm == cps_hdlc_pkg::S_IDLE;
  endsequence

  a_init_set: assert property (s_accept |=> q.w0.init)
    else $error("init bit not set after first packet");
  a_len_report: assert property (s_accept ##0
    (q.w10.length_error_report_en && PKT.li != q.w10.exp_li)
    |=> REPORT.len && q.status.len)
    else $error("length error not reported");
  a_len_quiet: assert property (REPORT.len |->
    $past(q.w10.length_error_report_en))
    else $error("length report while disabled");
  a_uui_report: assert property (REPORT.uui |->
    $past(q.w10.uui_error_report_en) &&
    $past(PKT.uui[3:0] & mmask) != $past(q.cfg.exp_uui & mmask))
    else $error("uui report without mismatch");
  a_loss_gate: assert property (REPORT.loss |->
    $past(q.w0.loss_report_en))
    else $error("loss reported while disabled");
  a_ref_pulse: assert property (s_accept ##0 (PKT.timing &&
    q.w8.ref_a_en) |=> REF_A ##1 !REF_A)
    else $error("reference a pulse wrong");
  a_hdr_none: assert property (s_accept ##0
    (q.w0.hdr_type == cps_hdlc_pkg::HDR_NONE)
    |=> q.fsm == cps_hdlc_pkg::S_DATA)
    else $error("no-header code entered header state");
  a_crc_tail: assert property (q.fsm == cps_hdlc_pkg::S_DATA &&
    IN_READY && IN_VALID && IN_LAST && q.w0.crc_en
    |=> q.fsm == cps_hdlc_pkg::S_CRC)
    else $error("crc not appended");
  a_wp_step: assert property (BUF_WR.we |->
    q.w0.wp == BUF_WR.addr + 9'h001)
    else $error("write pointer did not advance");
  a_rd_empty: assert property (RD_REQ && RD_EMPTY |=> !RD_VALID)
    else $error("read from empty buffer");
  a_ctl_uui: assert property (q.fsm == cps_hdlc_pkg::S_HDR && !q.st_v &&
    q.hidx == hcnt && q.w8.uui_in_control_en &&
    q.w0.hdr_type == cps_hdlc_pkg::HDR_A1C
    |=> q.sh[7:3] == q.uui)
    else $error("uui missing from control byte");
endmodule
`default_nettype wire

/* File: verif/cps_far_end.sv */
/*
  Far-end model: upstream CPS packet engine handing headers and payload.
  Assumes the block's ready outputs are settled by mid-cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cps_far_end (
  input wire logic clk,
  input wire logic pkt_ready,
  input wire logic in_ready,
  output logic pkt_valid,
  output cps_hdlc_pkg::pkt_t pkt,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_last
);
  initial begin
    pkt_valid = 1'b0;
    pkt = '0;
    in_valid = 1'b0;
    in_data = 8'h00;
    in_last = 1'b0;
  end

  // released lines are inverted so a stale byte never passes as valid
  task automatic send(input logic [5:0] li, input logic [4:0] uui,
                      input logic tm, input int n, input int gap);
    @(posedge clk);
    pkt_valid <= 1'b1;
    pkt <= '{li, uui, tm};
    do @(negedge clk); while (pkt_ready !== 1'b1);
    @(posedge clk);
    pkt_valid <= 1'b0;
    pkt <= ~pkt;
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge clk);
      in_valid <= 1'b1;
      in_data <= 8'h30 + 8'(i);
      in_last <= (i == n - 1);
      do @(negedge clk); while (in_ready !== 1'b1);
      @(posedge clk);
      if (gap > 0 || i == n - 1) begin
        in_valid <= 1'b0;
        in_last <= 1'b0;
        in_data <= ~(8'h30 + 8'(i));
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: verif/cps_hdlc_disasm_test.sv */
/*
  Self-checking bench for the CPS to HDLC disassembly block: framing,
  reports, interrupt, readout. Assumes the far-end model cps_far_end.
*/
`timescale 1ns/1ps
`default_nettype none
module cps_hdlc_disasm_test;
  logic clk, rst, wr, rd, desc_ovr, rd_req, pkt_ready, pkt_valid;
  logic in_valid, in_last, in_ready, rd_valid, rd_empty, ref_a, ref_b;
  logic irq;
  logic [4:0] addr;
  logic [15:0] wdata, rdata, v, crc;
  logic [7:0] in_data;
  logic [8:0] rd_addr, wp_exp = 9'h000, rp_exp = 9'h000;
  logic [9:0] stream;
  cps_hdlc_pkg::pkt_t pkt;
  cps_hdlc_pkg::wr_t buf_wr;
  cps_hdlc_pkg::evt_t report;
  logic [7:0] got_q[$], exp_q[$];
  int bad_count = 0, n_compared = 0, na = 0, nb = 0, nl = 0, nu = 0;
  int nlo = 0;

  cps_hdlc_disasm uut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .PKT_VALID(pkt_valid), .PKT(pkt),
    .PKT_READY(pkt_ready), .IN_VALID(in_valid), .IN_DATA(in_data),
    .IN_LAST(in_last), .IN_READY(in_ready), .DESC_OVERRUN(desc_ovr),
    .BUF_WR(buf_wr), .RD_REQ(rd_req), .RD_VALID(rd_valid),
    .RD_ADDR(rd_addr), .RD_EMPTY(rd_empty), .STREAM_NUM(stream),
    .REF_A(ref_a), .REF_B(ref_b), .REPORT(report), .IRQ(irq));

  cps_far_end fe (.clk(clk), .pkt_ready(pkt_ready), .in_ready(in_ready),
    .pkt_valid(pkt_valid), .pkt(pkt), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (!rst && buf_wr.we === 1'b1) begin
      got_q.push_back(buf_wr.data);
      chk(16'(buf_wr.addr), 16'(wp_exp));
      wp_exp = wp_exp + 9'h001;
    end
    na += int'(ref_a === 1'b1);
    nb += int'(ref_b === 1'b1);
    nl += int'(report.len === 1'b1);
    nu += int'(report.uui === 1'b1);
    nlo += int'(report.loss === 1'b1);
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rreg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic tick(input bit d);
    @(posedge clk);
    rd_req <= !d;
    desc_ovr <= d;
    @(posedge clk);
    rd_req <= 1'b0;
    desc_ovr <= 1'b0;
    @(negedge clk);
  endtask

  // crc runs over header and payload only, before escaping
  task automatic push(input logic [7:0] b, input bit upd);
    if (upd) begin
      for (int i = 0; i < 8; i++)
        crc = (crc >> 1) ^ ((crc[0] ^ b[i]) ? 16'h8408 : 16'h0000);
    end
    if (b == 8'h7E || b == 8'h7D) begin
      exp_q.push_back(8'h7D);
      exp_q.push_back(b ^ 8'h20);
    end else begin
      exp_q.push_back(b);
    end
  endtask

  task automatic frame(input logic [2:0] h, input logic c,
                       input logic [4:0] u, input logic [5:0] li,
                       input int n, input logic tm);
    logic [15:0] f;
    exp_q = {};
    got_q = {};
    crc = 16'hFFFF;
    wreg(5'h00, {1'b0, h, c, 2'b00, wp_exp});
    if (h == 3'h1 || h == 3'h3) push(8'h12, 1);
    if (h == 3'h2 || h == 3'h4) begin
      push(8'h12, 1);
      push(8'h12, 1);
    end
    if (h == 3'h3 || h == 3'h4) push({u, 3'b101}, 1);
    for (int i = 0; i < n; i++) push(8'h30 + 8'(i), 1);
    f = ~crc;
    if (c) begin
      push(f[7:0], 0);
      push(f[15:8], 0);
    end
    exp_q.push_back(8'h7E);
    fe.send(li, u, tm, n, int'(h));
    for (int k = 0; k < 200 && !(got_q.size() > 0 && got_q[$] == 8'h7E);
         k++) @(posedge clk);
    chk(16'(got_q.size()), 16'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++)
      chk(16'(got_q[i]), 16'(exp_q[i]));
    rreg(5'h00, v);
    chk(16'(v[9:0]), 16'({1'b1, wp_exp}));
  endtask

  task automatic ev(input logic [5:0] li, input logic [4:0] u,
                    input int el, input int eu);
    nl = 0;
    nu = 0;
    frame(3'h0, 1'b0, u, li, 1, 1'b0);
    repeat (2) @(posedge clk);
    chk(16'(nl), 16'(el));
    chk(16'(nu), 16'(eu));
  endtask

  task automatic ref_case(input logic [15:0] w, input int ea, input int eb);
    wreg(5'h08, w);
    na = 0;
    nb = 0;
    frame(3'h0, 1'b0, 5'h03, 6'h05, 1, 1'b1);
    chk(16'(na), 16'(ea));
    chk(16'(nb), 16'(eb));
  endtask

  // bit mode packs LSB first; a partial byte stays behind in the packer
  task automatic bit_case();
    bit bq[$];
    logic [7:0] b;
    logic [7:0] seq[6];
    logic [15:0] f;
    int ones;
    ones = 0;
    got_q = {};
    crc = 16'hFFFF;
    seq = '{8'hFF, 8'hFF, 8'h30, 8'h31, 8'h00, 8'h00};
    wreg(5'h16, 16'h00A1);
    wreg(5'h06, 16'hFFFF);
    wreg(5'h00, {4'h2, 1'b1, 2'b00, wp_exp});
    for (int i = 0; i < 4; i++) push(seq[i], 1);
    f = ~crc;
    seq[4] = f[7:0];
    seq[5] = f[15:8];
    exp_q = {};
    for (int i = 0; i < 7; i++) begin
      b = (i < 6) ? seq[i] : 8'h7E;
      for (int j = 0; j < 8; j++) begin
        if (ones == 5) begin
          bq.push_back(1'b0);
          ones = 0;
        end
        bq.push_back(b[j]);
        ones = (b[j] && i < 6) ? ones + 1 : 0;
      end
    end
    for (int i = 0; i + 8 <= bq.size(); i += 8) begin
      for (int j = 0; j < 8; j++) b[j] = bq[i + j];
      exp_q.push_back(b);
    end
    fe.send(6'h05, 5'h03, 1'b0, 2, 0);
    for (int k = 0; k < 300 && got_q.size() < exp_q.size(); k++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    chk(16'(got_q.size()), 16'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++)
      chk(16'(got_q[i]), 16'(exp_q[i]));
    rreg(5'h00, v);
    chk(16'(v[9:0]), 16'({1'b1, wp_exp}));
  endtask

  task automatic drain();
    for (int k = 0; k < 600 && rd_empty !== 1'b1; k++) begin
      tick(0);
      chk(16'(rd_valid), 16'h0001);
      chk(16'(rd_addr), 16'(rp_exp));
      rp_exp++;
    end
    chk(16'(rp_exp), 16'(wp_exp));
    tick(0);
    chk(16'(rd_valid), 16'h0000);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    desc_ovr = 1'b0;
    rd_req = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rreg(5'h00, v);
    chk(v, 16'h0000);
    chk(16'(rd_empty), 16'h0001);
    rreg(5'h1E, v);
    chk(v, 16'h0000);
    wreg(5'h04, 16'h03FF);
    rreg(5'h04, v);
    chk(v, 16'h03FF);
    chk(16'(stream), 16'h03FF);
    wreg(5'h06, 16'h1212);
    wreg(5'h08, 16'h0155);
    for (int h = 0; h < 5; h++) frame(3'(h), h > 1, 5'h13, 6'h05, 2, 1'b0);
    drain();
    wreg(5'h16, 16'h00A0);
    wreg(5'h10, 16'h05C1);
    ev(6'h06, 5'h0A, 1, 0);
    ev(6'h05, 5'h0B, 0, 1);
    for (int s = 0; s < 5; s++) begin
      wreg(5'h10, 16'h05C0 | (16'h0010 >> s));
      ev(6'h05, 5'h03, 0, int'(s > 0));
    end
    wreg(5'h10, 16'h0001);
    ev(6'h06, 5'h03, 0, 0);
    rreg(5'h12, v);
    chk(v & 16'h0003, 16'h0003);
    chk(16'(irq), 16'h0000);
    wreg(5'h14, 16'h0003);
    chk(16'(irq), 16'h0001);
    wreg(5'h12, 16'h0007);
    chk(16'(irq), 16'h0000);
    rreg(5'h00, v);
    wreg(5'h00, v | 16'h0400);
    nlo = 0;
    tick(1);
    @(negedge clk);
    chk(16'(nlo), 16'h0001);
    wreg(5'h14, 16'h0004);
    chk(16'(irq), 16'h0001);
    wreg(5'h12, 16'h0004);
    wreg(5'h00, v & 16'hFBFF);
    tick(1);
    repeat (2) @(posedge clk);
    chk(16'(nlo), 16'h0001);
    ref_case(16'h2155, 1, 0);
    ref_case(16'h1155, 0, 1);
    bit_case();
    drain();
    complete_run();
  end
endmodule
`default_nettype wire
